//--- design/pwm_deadtime_and_trigger.sv
// Purpose: Deadtime insertion for pair 0 and hardware trigger logic
// Assumes: Timer count, compare values and PWM come from the same clock
// Notes:   APB slave, zero wait states, unmapped address gives pslverr
//
// Operation
// - Prescale select divides clock by 1 or 4
// - Deadtime counter advances only on prescaled tick
// - One prescale and count shared by all
// - Count value inserts that many counts, 0..63
// - Deadtime cycles equal factor times count
// - Deadtime fields writable only when unprotected
// - Upper bits 31..8 read as zero
// - Any channel trigger sets the flag
// - Flag clears by read then zero write
// - Writing one to flag does nothing
// - New trigger restarts the clearing sequence
// - Init enable triggers on counter equal initial
// - Channel enable bits map to channel compares
// - Channels 6 and 7 never trigger
// - Any trigger enable combination allowed together
// - Pair deadtime only when pair enable set
// - Complementary mode inverts odd channel output
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module pwm_deadtime_and_trigger
    import pwm_dt_trig_pkg::*;
#(
    parameter int CW = CNT_W
)(
    // Clock and reset
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    // APB slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [ADDR_W-1:0]               paddr,
    input  wire logic [DATA_W-1:0]               pwdata,
    output logic                                 pready,
    output logic [DATA_W-1:0]                    prdata,
    output logic                                 pslverr,
    // Timer values
    input  wire logic [CW-1:0]                   timer_count,
    input  wire logic [CW-1:0]                   counter_initial_value,
    input  wire logic [NUM_TRIG_CH-1:0][CW-1:0]  channel_compare_value,
    // Pair 0 PWM in and out
    input  wire logic                            pwm_even_in,
    output logic                                 chan0_out,
    output logic                                 chan1_out,
    // Triggers and interrupt
    output logic                                 chan_trigger_pulse,
    output logic                                 init_trigger_pulse,
    output logic                                 irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [DT_PS_W-1:0]     ps_sel;
        logic [DT_VAL_W-1:0]    dt_val;
        logic                   init_en;
        logic [NUM_TRIG_CH-1:0] chan_en;
        logic                   trig_flag;
        logic                   clear_armed;
        logic                   wpd;
        logic                   dt_en;
        logic                   comp_en;
        logic [IRQ_W-1:0]       irq_status;
        logic [IRQ_W-1:0]       irq_mask;
        logic                   pready;
        logic                   pslverr;
        logic [DATA_W-1:0]      prdata;
        logic [NUM_TRIG_CH-1:0] chan_match_prev;
        logic                   init_match_prev;
        logic                   chan_trig;
        logic                   init_trig;
        logic [1:0]             pair_tgt;
        logic [1:0]             pair_out;
        logic                   dt_busy;
        logic [DT_VAL_W-1:0]    dt_cnt;
        logic                   irq;
    } state_s;

    state_s s_reg;
    state_s s_next;
    logic   dt_restart;
    logic   dt_tick;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Address decode, used for the error answer that also blocks the access
    function automatic logic addr_valid(input logic [ADDR_W-1:0] a);
        return (a == OFS_DEADTIME) || (a == OFS_EXTTRIG) ||
               (a == OFS_PAIR_CTRL) || (a == OFS_IRQ_STATUS) ||
               (a == OFS_IRQ_MASK);
    endfunction

    // Read word; all unlisted bits read zero
    function automatic logic [DATA_W-1:0] read_word(
        input state_s               st,
        input logic [ADDR_W-1:0]    a
    );
        logic [DATA_W-1:0] w;
        w = WORD_ZERO;
        unique case (a)
            OFS_DEADTIME: begin
                w[DT_PS_LO +: DT_PS_W]   = st.ps_sel;
                w[DT_VAL_LO +: DT_VAL_W] = st.dt_val;
            end
            OFS_EXTTRIG: begin
                w[TRIG_FLAG_BIT]                = st.trig_flag;
                w[INIT_EN_BIT]                  = st.init_en;
                w[CHAN_EN_LO +: NUM_TRIG_CH]    = st.chan_en;
            end
            OFS_PAIR_CTRL: begin
                w[PAIR_WPD_BIT]  = st.wpd;
                w[PAIR_DTEN_BIT] = st.dt_en;
                w[PAIR_COMP_BIT] = st.comp_en;
            end
            OFS_IRQ_STATUS: w[IRQ_W-1:0] = st.irq_status;
            OFS_IRQ_MASK:   w[IRQ_W-1:0] = st.irq_mask;
            default:        w = WORD_ZERO;
        endcase
        return w;
    endfunction

    // ************************************************************
    // Shared prescaler
    // ************************************************************
    // One prescaler for every pair, fed by the single setting
    deadtime_prescaler u_prescaler (
        .clk          (clk),
        .rst_n        (rst_n),
        .restart      (dt_restart),
        .prescale_sel (s_reg.ps_sel),
        .tick         (dt_tick)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic                   access;
        logic                   wr;
        logic                   rd;
        logic [NUM_TRIG_CH-1:0] chan_match;
        logic                   init_match;
        logic                   chan_hit;
        logic                   init_hit;
        logic [1:0]             tgt;
        access     = 1'b0;
        wr         = 1'b0;
        rd         = 1'b0;
        chan_match = '0;
        init_match = 1'b0;
        chan_hit   = 1'b0;
        init_hit   = 1'b0;
        tgt        = '0;
        s_next     = s_reg;
        dt_restart = 1'b0;

        // APB setup phase prepares a zero-wait answer
        s_next.pready  = 1'b0;
        s_next.pslverr = 1'b0;
        if (psel && !penable) begin
            s_next.pready  = 1'b1;
            s_next.pslverr = !addr_valid(paddr);
            s_next.prdata  = read_word(s_reg, paddr);
        end
        access = psel && penable && s_reg.pready;
        wr     = access && pwrite && !s_reg.pslverr;
        rd     = access && !pwrite && !s_reg.pslverr;

        // Register writes, effective at the access edge
        if (wr) begin
            unique case (paddr)
                OFS_DEADTIME: begin
                    if (s_reg.wpd) begin
                        s_next.ps_sel = pwdata[DT_PS_LO +: DT_PS_W];
                        s_next.dt_val = pwdata[DT_VAL_LO +: DT_VAL_W];
                    end
                end
                OFS_EXTTRIG: begin
                    s_next.init_en = pwdata[INIT_EN_BIT];
                    s_next.chan_en = pwdata[CHAN_EN_LO +: NUM_TRIG_CH];
                    // A one leaves the flag alone
                    if (!pwdata[TRIG_FLAG_BIT] && s_reg.clear_armed) begin
                        s_next.trig_flag   = 1'b0;
                        s_next.clear_armed = 1'b0;
                    end
                end
                OFS_PAIR_CTRL: begin
                    s_next.wpd = pwdata[PAIR_WPD_BIT];
                    if (s_reg.wpd) begin
                        s_next.dt_en   = pwdata[PAIR_DTEN_BIT];
                        s_next.comp_en = pwdata[PAIR_COMP_BIT];
                    end
                end
                OFS_IRQ_STATUS: begin
                    s_next.irq_status = s_reg.irq_status &
                                        ~pwdata[IRQ_W-1:0];
                end
                OFS_IRQ_MASK: s_next.irq_mask = pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        // Read of the trigger register with flag seen set arms the clear
        if (rd && (paddr == OFS_EXTTRIG) && s_reg.prdata[TRIG_FLAG_BIT]) begin
            s_next.clear_armed = 1'b1;
        end

        // Compare matches; only channels 0..5 exist here
        for (int i = 0; i < NUM_TRIG_CH; i++) begin
            chan_match[i] = s_reg.chan_en[CHAN_EN_POS[i]] &&
                            (timer_count == channel_compare_value[i]);
        end
        init_match = s_reg.init_en &&
                     (timer_count == counter_initial_value);

        // Rising edge of a match gives a single pulse
        chan_hit = |(chan_match & ~s_reg.chan_match_prev);
        init_hit = init_match && !s_reg.init_match_prev;
        s_next.chan_match_prev = chan_match;
        s_next.init_match_prev = init_match;
        s_next.chan_trig       = chan_hit;
        s_next.init_trig       = init_hit;

        // Set wins over the clear and disarms a pending sequence
        if (chan_hit) begin
            s_next.trig_flag   = 1'b1;
            s_next.clear_armed = 1'b0;
        end
        if (chan_hit) begin
            s_next.irq_status[IRQ_CHAN_BIT] = 1'b1;
        end
        if (init_hit) begin
            s_next.irq_status[IRQ_INIT_BIT] = 1'b1;
        end
        s_next.irq = |(s_next.irq_status & s_next.irq_mask);

        // Pair target: odd is inverse of even in complementary mode
        tgt[0] = pwm_even_in;
        tgt[1] = s_reg.comp_en ? !pwm_even_in : pwm_even_in;

        // Outputs going inactive drop at once; rising ones wait
        if (tgt != s_reg.pair_tgt) begin
            s_next.pair_tgt = tgt;
            if (s_reg.dt_en && (s_reg.dt_val != '0)) begin
                s_next.pair_out = s_reg.pair_out & tgt;
                s_next.dt_busy  = 1'b1;
                s_next.dt_cnt   = s_reg.dt_val;
                dt_restart      = 1'b1;
            end else begin
                s_next.pair_out = tgt;
                s_next.dt_busy  = 1'b0;
            end
        end else if (s_reg.dt_busy && dt_tick) begin
            // Last tick lands exactly factor*count cycles after the edge
            if (s_reg.dt_cnt == DT_CNT_LAST) begin
                s_next.pair_out = s_reg.pair_tgt;
                s_next.dt_busy  = 1'b0;
            end
            s_next.dt_cnt = s_reg.dt_cnt - DT_CNT_LAST;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flops
    assign pready             = s_reg.pready;
    assign prdata             = s_reg.prdata;
    assign pslverr            = s_reg.pslverr;
    assign chan0_out          = s_reg.pair_out[0];
    assign chan1_out          = s_reg.pair_out[1];
    assign chan_trigger_pulse = s_reg.chan_trig;
    assign init_trigger_pulse = s_reg.init_trig;
    assign irq                = s_reg.irq;

endmodule // pwm_deadtime_and_trigger

//--- design/pwm_dt_trig_pkg.sv
// Purpose: Shared constants for the deadtime and trigger block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   All offsets are byte addresses
package pwm_dt_trig_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADDR_W      = 12;
    localparam int DATA_W      = 32;
    localparam int CNT_W       = 16;
    localparam int NUM_TRIG_CH = 6;
    localparam int DT_PS_W     = 2;
    localparam int DT_VAL_W    = 6;
    localparam int IRQ_W       = 2;
    localparam int PS_CNT_W    = 2;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_DEADTIME   = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_EXTTRIG    = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_PAIR_CTRL  = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 12'h010;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int DT_PS_LO      = 6;
    localparam int DT_VAL_LO     = 0;
    localparam int TRIG_FLAG_BIT = 7;
    localparam int INIT_EN_BIT   = 6;
    localparam int CHAN_EN_LO    = 0;
    localparam int PAIR_WPD_BIT  = 0;
    localparam int PAIR_DTEN_BIT = 1;
    localparam int PAIR_COMP_BIT = 2;
    localparam int IRQ_CHAN_BIT  = 0;
    localparam int IRQ_INIT_BIT  = 1;

    // Enable bit position for channels 0..5
    localparam int CHAN_EN_POS [NUM_TRIG_CH] = '{4, 5, 0, 1, 2, 3};

    // ************************************************************
    // Prescale encodings and reset values
    // ************************************************************
    localparam logic [DT_PS_W-1:0]  PS_DIV4     = 2'h2;
    localparam logic [PS_CNT_W-1:0] PS_MAX_DIV1 = 2'h0;
    localparam logic [PS_CNT_W-1:0] PS_MAX_DIV4 = 2'h3;
    localparam logic [DATA_W-1:0]   WORD_ZERO   = 32'h0000_0000;
    localparam logic [DT_VAL_W-1:0] DT_CNT_LAST = 6'h01;

endpackage

//--- design/deadtime_prescaler.sv
// Purpose: Prescaled tick for the deadtime counter
// Assumes: Same clock as the register block
// Notes:   Restart aligns the first tick to a full prescale period
`timescale 1ns/1ps
module deadtime_prescaler
    import pwm_dt_trig_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Control
    input  wire logic               restart,
    input  wire logic [DT_PS_W-1:0] prescale_sel,
    // Tick out
    output logic                    tick
);

    typedef struct packed {
        logic [PS_CNT_W-1:0] cnt;
    } pre_s;

    pre_s                s_reg;
    pre_s                s_next;
    logic [PS_CNT_W-1:0] cnt_max;

    // ************************************************************
    // Divide logic
    // ************************************************************
    // Code 11 is treated as divide by 4, same as 10
    always_comb begin
        s_next  = s_reg;
        cnt_max = prescale_sel[DT_PS_W-1] ? PS_MAX_DIV4 : PS_MAX_DIV1;
        tick    = (s_reg.cnt == cnt_max);
        if (restart || tick) begin
            s_next.cnt = '0;
        end else begin
            s_next.cnt = s_reg.cnt + PS_CNT_W'(1);
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule // deadtime_prescaler

//--- testbench/dt_trig_props.sv
// Purpose: Port assertions for the deadtime and trigger block
// Assumes: Single clock, async active-low reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
module dt_trig_props
    import pwm_dt_trig_pkg::*;
#(
    parameter int CW = CNT_W
)(
    // Clock and reset
    input wire logic                          clk,
    input wire logic                          rst_n,
    // APB
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [ADDR_W-1:0]             paddr,
    input wire logic [DATA_W-1:0]             pwdata,
    input wire logic                          pready,
    input wire logic [DATA_W-1:0]             prdata,
    input wire logic                          pslverr,
    // Timer values
    input wire logic [CW-1:0]                 timer_count,
    input wire logic [CW-1:0]                 counter_initial_value,
    input wire logic [NUM_TRIG_CH-1:0][CW-1:0] channel_compare_value,
    // Pair and triggers
    input wire logic                          pwm_even_in,
    input wire logic                          chan0_out,
    input wire logic                          chan1_out,
    input wire logic                          chan_trigger_pulse,
    input wire logic                          init_trigger_pulse,
    input wire logic                          irq
);
    // ****************************************************
    // Checks
    // ****************************************************
    logic any_eq;

    // Any compare hit, enabled or not; a pulse needs one
    always_comb begin
        any_eq = 1'b0;
        for (int i = 0; i < NUM_TRIG_CH; i++) begin
            any_eq = any_eq | (timer_count == channel_compare_value[i]);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_with_ready_a: assert property (pslverr |-> pready && prdata == 0)
        else $error("pslverr outside answer");
    dt_upper_zero_a: assert property (pready && !pwrite &&
        paddr == OFS_DEADTIME |-> prdata[31:8] == 0)
        else $error("deadtime upper bits set");
    ext_upper_zero_a: assert property (pready && !pwrite &&
        paddr == OFS_EXTTRIG |-> prdata[31:8] == 0)
        else $error("trigger upper bits set");
    chan_cause_a: assert property (
        chan_trigger_pulse |-> $past(any_eq))
        else $error("channel pulse without match");
    chan_single_a: assert property (
        chan_trigger_pulse |=> !chan_trigger_pulse)
        else $error("channel pulse too long");
    init_cause_a: assert property (init_trigger_pulse |->
        $past(timer_count == counter_initial_value))
        else $error("init pulse without match");
    init_single_a: assert property (
        init_trigger_pulse |=> !init_trigger_pulse)
        else $error("init pulse too long");
endmodule // dt_trig_props

bind pwm_deadtime_and_trigger dt_trig_props #(.CW(CW)) u_props (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .timer_count(timer_count),
    .counter_initial_value(counter_initial_value),
    .channel_compare_value(channel_compare_value),
    .pwm_even_in(pwm_even_in), .chan0_out(chan0_out),
    .chan1_out(chan1_out), .chan_trigger_pulse(chan_trigger_pulse),
    .init_trigger_pulse(init_trigger_pulse), .irq(irq)
);

//--- testbench/trig_consumer.sv
// Purpose: Model of an on-chip consumer of hardware triggers
// Assumes: Pulses arrive in the block's clock domain
// Notes:   Counts every high cycle, so a stretched pulse over-counts
`timescale 1ns/1ps
module trig_consumer (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Trigger pulses
    input  wire logic chan_pulse,
    input  wire logic init_pulse,
    // Counts seen
    output int        chan_seen,
    output int        init_seen
);
    // One event per cycle of high pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_seen <= 0;
            init_seen <= 0;
        end else begin
            chan_seen <= chan_seen + int'(chan_pulse);
            init_seen <= init_seen + int'(init_pulse);
        end
    end
endmodule // trig_consumer

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the deadtime and trigger block
// Assumes: Zero or more APB wait states, single clock
// Notes:   Expected values come from a model kept in the bench
`timescale 1ns/1ps
module tb_top
    import pwm_dt_trig_pkg::*;
;
    // ****************************************************
    // Signals
    // ****************************************************
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic pwm_even_in = 0, pready, pslverr, err;
    logic chan0_out, chan1_out, ctp, itp, irq;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd;
    logic [CNT_W-1:0]  tcnt = '1, civ = '0;
    logic [NUM_TRIG_CH-1:0][CNT_W-1:0] ccv = '0;
    logic [7:0] en = '0;
    int num_errors = 0, num_checks = 0, flag = 0, armed = 0;
    int exp_ct = 0, exp_it = 0, chan_seen, init_seen;

    always #5 clk = ~clk;

    pwm_deadtime_and_trigger DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .timer_count(tcnt), .counter_initial_value(civ),
        .channel_compare_value(ccv), .pwm_even_in(pwm_even_in),
        .chan0_out(chan0_out), .chan1_out(chan1_out),
        .chan_trigger_pulse(ctp), .init_trigger_pulse(itp), .irq(irq));
    trig_consumer u_cons (.clk(clk), .rst_n(rst_n), .chan_pulse(ctp),
        .init_pulse(itp), .chan_seen(chan_seen), .init_seen(init_seen));

    // ****************************************************
    // Tasks
    // ****************************************************
    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Full APB transfer; waits for pready, never assumes latency
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            num_errors++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Trigger register read; a read seeing the flag arms the clear
    task automatic rdext();
        apb(1'b0, OFS_EXTTRIG, '0);
        check("trigger reg", rd, {24'h0, flag[0], en[6:0]});
        if (flag != 0) armed = 1;
    endtask

    task automatic wext(input logic b);
        apb(1'b1, OFS_EXTTRIG, {24'h0, b, en[6:0]});
        if (!b && armed != 0) flag = 0;
        armed = 0;
    endtask

    // Present one compare match; index 6 is the initial value
    task automatic hit(input int i);
        @(posedge clk);
        tcnt <= (i == 6) ? civ : ccv[i];
        @(posedge clk);
        tcnt <= '1;
        @(posedge clk);
        if (i == 6) begin
            check("init pulse", itp, en[6]);
            check("no chan pulse", ctp, 0);
            exp_it += en[6];
        end else begin
            check("chan pulse", ctp, en[CHAN_EN_POS[i]]);
            if (en[CHAN_EN_POS[i]]) begin
                flag = 1;
                armed = 0;
                exp_ct++;
            end
        end
    endtask

    // Gap between the falling and the rising output, both directions
    task automatic dt(input logic [1:0] s, input int v, input logic de);
        int k, fall, rise, both;
        apb(1'b1, OFS_DEADTIME, {24'h0, s, v[5:0]});
        apb(1'b1, OFS_PAIR_CTRL, {29'h0, 1'b1, de, 1'b1});
        repeat (260) @(posedge clk);
        for (int d = 0; d < 2; d++) begin
            @(posedge clk);
            pwm_even_in <= ~pwm_even_in;
            fall = -1;
            rise = -1;
            both = 0;
            for (k = 1; k < 300 && rise < 0; k++) begin
                @(posedge clk);
                if (chan0_out && chan1_out) both++;
                if (fall < 0 && (pwm_even_in ? !chan1_out : !chan0_out))
                    fall = k;
                if (pwm_even_in ? chan0_out : chan1_out) rise = k;
            end
            if (rise < 0) begin
                num_errors++;
                conclude();
            end
            check("deadtime", rise - fall,
                  de ? (s[1] ? 4 : 1) * v : 0);
            check("overlap", both, 0);
        end
    endtask

    // ****************************************************
    // Sequence
    // ****************************************************
    initial begin
        void'($urandom(32'h7c17));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        civ <= 16'h0800 + 16'($urandom_range(0, 255));
        for (int i = 0; i < NUM_TRIG_CH; i++)
            ccv[i] <= 16'(16'h1000 * (i + 1) + $urandom_range(0, 255));
        // Protection, reserved bits and unmapped space
        apb(1'b1, OFS_DEADTIME, 32'h0000_00FF);
        apb(1'b0, OFS_DEADTIME, '0);
        check("locked deadtime", rd, 0);
        apb(1'b1, OFS_PAIR_CTRL, 32'h0000_0001);
        apb(1'b1, OFS_DEADTIME, 32'hFFFF_FFFF);
        apb(1'b0, OFS_DEADTIME, '0);
        check("deadtime reg", rd, 32'h0000_00FF);
        check("mapped no err", err, 0);
        apb(1'b0, 12'h020, '0);
        check("unmapped err", err, 1);
        // Every channel enabled, then a random mix
        for (int p = 0; p < 2; p++) begin
            en = (p == 0) ? 8'h7F : 8'($urandom_range(0, 127));
            wext(1'b1);
            for (int i = 0; i < 7; i++) hit(i);
            rdext();
        end
        // Flag clearing sequence
        en = 8'h7F;
        wext(1'b1);
        hit(0);
        wext(1'b0);
        rdext();
        hit(1);
        wext(1'b0);
        rdext();
        wext(1'b1);
        rdext();
        wext(1'b0);
        rdext();
        // Interrupt status, mask and clear
        apb(1'b0, OFS_IRQ_STATUS, '0);
        check("irq status", rd, 3);
        check("irq masked", irq, 0);
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
        @(posedge clk);
        check("irq raised", irq, 1);
        apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0002);
        @(posedge clk);
        check("irq cleared", irq, 0);
        apb(1'b0, OFS_IRQ_STATUS, '0);
        check("irq status", rd, 1);
        // Deadtime table of prescale, count and enable
        dt(2'b10, 2, 1'b1);
        dt(2'b00, 5, 1'b1);
        dt(2'b11, 63, 1'b1);
        dt(2'b01, 0, 1'b1);
        dt(2'b10, 7, 1'b0);
        check("chan consumed", chan_seen, exp_ct);
        check("init consumed", init_seen, exp_it);
        conclude();
    end
endmodule // tb_top
